//--- hdl/flash_prot_map.vh
// Purpose: offsets, field positions, reset values and address constants for the
//          flash configuration and protection registers
// Assumes: included by bare name from the design files
// Notes:   byte addresses are four times the register index
`ifndef FLASH_PROT_MAP_VH
`define FLASH_PROT_MAP_VH

// ==========================================================================
// Register indices
`define IDX_FLASH_CONFIG 4'h3
`define IDX_FLASH_PROTECTION 4'h4
`define IDX_SECURITY 4'h8
`define IDX_VIOL_STATUS 4'h9
`define IDX_STATUS_IN 4'hA

// ==========================================================================
// Configuration field positions
`define CFG_BEIE_BIT 7
`define CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT 6
`define CFG_KEYW_BIT 5
`define CFG_IMPL_MASK 8'hE0

// ==========================================================================
// Protection field positions
`define PROT_POL_BIT 7
`define PROT_NV6_BIT 6
`define PROT_HDIS_BIT 5
`define PROT_HS_HI 4
`define PROT_HS_LO 3
`define PROT_LDIS_BIT 2
`define PROT_LS_HI 1
`define PROT_LS_LO 0

// ==========================================================================
// Reset values and security encodings
`define CFG_RESET 8'h00
`define PROT_RESET 8'hFF
`define SEC_RESET 8'h00
`define KEY_ENABLED 2'h2
`define BACKDOOR_KEY_ENABLE_FIELD_HI 7
`define BACKDOOR_KEY_ENABLE_FIELD_LO 6

// ==========================================================================
// Flash addresses and ranges
`define PROT_BYTE_ADDR 16'hFF0D
`define SEC_BYTE_ADDR 16'hFF0F
`define HIGH_RANGE_END 16'hFFFF
`define LOW_RANGE_BASE 16'h4000

`endif

//--- hdl/prot_range_check.v
// Purpose: decide whether one flash address is protected under a protection byte
// Assumes: protection byte layout from the map header
// Notes:   purely combinational
`include "flash_prot_map.vh"
`default_nettype none

module prot_range_check (
  input wire [7:0] i_prot,
  input wire [15:0] i_addr,
  output wire o_protected,
  output wire o_fully_open
);

  // ==========================================================================
  // Range decode
  wire [1:0] hs = i_prot[`PROT_HS_HI:`PROT_HS_LO];
  wire [1:0] ls = i_prot[`PROT_LS_HI:`PROT_LS_LO];
  wire pol = i_prot[`PROT_POL_BIT];
  wire hdis = i_prot[`PROT_HDIS_BIT];
  wire ldis = i_prot[`PROT_LDIS_BIT];
  // High range: 2K shifted left by size code, always ending at top
  wire [15:0] high_base = 16'h0000 - (16'h0800 << hs);
  // Low range: 1K shifted left by size code, from 0x4000
  wire [15:0] low_last = `LOW_RANGE_BASE + (16'h0400 << ls) - 16'h0001;
  wire in_high = (i_addr >= high_base);
  wire in_low = (i_addr >= `LOW_RANGE_BASE) && (i_addr <= low_last);

  // Polarity swaps the meaning of the disable bits
  wire hit_high = !hdis && in_high;
  wire hit_low = !ldis && in_low;
  assign o_protected = pol ? (hit_high || hit_low) : !(hit_high || hit_low);
  assign o_fully_open = pol && hdis && ldis;

endmodule

`default_nettype wire

//--- hdl/flash_config_protection_regs.v
// Purpose: configuration and protection registers of a flash controller
// Assumes: classic Wishbone slave, 25 MHz clock, synchronous active-low reset
// Notes:   program/erase engine and status register live outside this block
// Function
// - Config byte holds bits 7,6,5 only; others read zero.
// - Key-write bit writable only when backdoor key field is enabled.
// - Buffer-empty enable gates buffer-empty flag onto an interrupt request.
// - Command-complete enable gates complete flag onto an interrupt request.
// - Key-write clear: array writes start command sequences.
// - Key-write set: array writes are keys, array reads invalid.
// - Protection byte readable in all modes.
// - Polarity bit can only go from one to zero.
// - Low size field writable only while low disable set.
// - High size field writable only while high disable set.
// - Protection byte loaded from flash 0xFF0D during reset sequence.
// - Program/erase at protected address blocked, violation flag set.
// - Mass erase only when fully unprotected, else violation.
// - Polarity swaps meaning of range disable bits.
// - High disable zero enables high range.
// - Low disable zero enables low range.
// - High range sizes 2K to 16K ending at 0xFFFF.
// - Low range sizes 1K to 8K starting at 0x4000.
// - Writes that remove protection are ignored entirely.
// - Backdoor key enabled only for encoding 10.
`include "flash_prot_map.vh"
`default_nettype none

module flash_config_protection_regs (
  input wire i_clock,
  input wire i_rst_n,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [5:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output wire o_wb_ack,
  // Reset-sequence loader reads flash bytes
  output reg o_load_req,
  output reg [15:0] o_load_addr,
  input wire i_load_valid,
  input wire [7:0] i_load_data,
  // Flags from the command controller
  input wire i_buffer_empty_flag,
  input wire i_commands_complete_flag,
  output wire o_buffer_empty_irq,
  output wire o_command_complete_irq,
  // Array access steering
  input wire i_array_write,
  output wire o_start_command,
  output wire o_key_word_write,
  output wire o_read_invalid,
  // Program/erase command check
  input wire i_cmd_valid,
  input wire i_cmd_mass_erase,
  input wire [15:0] i_cmd_addr,
  output wire o_cmd_allow,
  output reg o_protection_violation_flag,
  input wire i_viol_clear,
  output wire o_load_done
);

  // ==========================================================================
  // State
  localparam ST_LOAD_SEC = 2'b00;
  localparam ST_LOAD_PROT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [7:0] flash_config;
  reg [7:0] flash_protection;
  reg [7:0] security_register;
  reg ack;

  wire [3:0] idx = i_wb_adr[5:2];
  wire bus_req = i_wb_cyc && i_wb_stb && !ack;
  wire wr_lane0 = bus_req && i_wb_we && i_wb_sel[0];
  wire [7:0] wdat = i_wb_dat[7:0];
  wire key_ok = (security_register[`BACKDOOR_KEY_ENABLE_FIELD_HI:`BACKDOOR_KEY_ENABLE_FIELD_LO] == `KEY_ENABLED);
  wire running = (state == ST_RUN);

  // ==========================================================================
  // Scenario numbering of a protection byte
  function [2:0] scenario;
    input [7:0] p;
    begin
      scenario = {~p[`PROT_POL_BIT], ~p[`PROT_HDIS_BIT], ~p[`PROT_LDIS_BIT]};
      // Map to 0..7 ordering: pol=1 -> 0..3 by protection added
      if (p[`PROT_POL_BIT])
        scenario = {1'b0, ~p[`PROT_HDIS_BIT], ~p[`PROT_LDIS_BIT]};
      else
        scenario = {1'b1, ~p[`PROT_LDIS_BIT], ~p[`PROT_HDIS_BIT]};
    end
  endfunction

  // Allowed transitions as a row mask per source scenario
  function allowed;
    input [2:0] from;
    input [2:0] to;
    reg [7:0] row;
    begin
      case (from)
        3'd0: row = 8'h0F;
        3'd1: row = 8'h0A;
        3'd2: row = 8'h0C;
        3'd3: row = 8'h08;
        3'd4: row = 8'h18;
        3'd5: row = 8'h3C;
        3'd6: row = 8'h5A;
        default: row = 8'hFF;
      endcase
      allowed = row[to];
    end
  endfunction

  // ==========================================================================
  // Candidate protection value from a bus write
  reg [7:0] next_prot;
  always @* begin
    next_prot = flash_protection;
    // Polarity only clears
    next_prot[`PROT_POL_BIT] = flash_protection[`PROT_POL_BIT] & wdat[`PROT_POL_BIT];
    next_prot[`PROT_NV6_BIT] = wdat[`PROT_NV6_BIT];
    next_prot[`PROT_HDIS_BIT] = wdat[`PROT_HDIS_BIT];
    next_prot[`PROT_LDIS_BIT] = wdat[`PROT_LDIS_BIT];
    if (flash_protection[`PROT_HDIS_BIT])
      next_prot[`PROT_HS_HI:`PROT_HS_LO] = wdat[`PROT_HS_HI:`PROT_HS_LO];
    if (flash_protection[`PROT_LDIS_BIT])
      next_prot[`PROT_LS_HI:`PROT_LS_LO] = wdat[`PROT_LS_HI:`PROT_LS_LO];
  end

  // Whole write dropped if the scenario step removes protection
  wire prot_write_ok = allowed(scenario(flash_protection), scenario(next_prot));

  // ==========================================================================
  // Reset-sequence loader, then software register writes
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= ST_LOAD_SEC;
      flash_config <= `CFG_RESET;
      flash_protection <= `PROT_RESET;
      security_register <= `SEC_RESET;
      o_load_req <= 1'b0;
      o_load_addr <= 16'h0000;
    end else begin
      case (state)
        ST_LOAD_SEC: begin
          o_load_req <= 1'b1;
          o_load_addr <= `SEC_BYTE_ADDR;
          if (o_load_req && i_load_valid) begin
            security_register <= i_load_data;
            o_load_addr <= `PROT_BYTE_ADDR;
            state <= ST_LOAD_PROT;
          end
        end
        ST_LOAD_PROT: begin
          if (i_load_valid) begin
            flash_protection <= i_load_data;
            o_load_req <= 1'b0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wr_lane0 && idx == `IDX_FLASH_CONFIG) begin
            flash_config[`CFG_BEIE_BIT] <= wdat[`CFG_BEIE_BIT];
            flash_config[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] <= wdat[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT];
            if (key_ok)
              flash_config[`CFG_KEYW_BIT] <= wdat[`CFG_KEYW_BIT];
          end
          if (wr_lane0 && idx == `IDX_FLASH_PROTECTION && prot_write_ok)
            flash_protection <= next_prot;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  assign o_load_done = running;

  // ==========================================================================
  // Bus answer: ack registered one cycle after the request, drops after one cycle
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      ack <= bus_req;
      o_wb_dat <= 32'h00000000;
      if (bus_req && !i_wb_we) begin
        case (idx)
          `IDX_FLASH_CONFIG: o_wb_dat <= {24'h000000, flash_config & `CFG_IMPL_MASK};
          `IDX_FLASH_PROTECTION: o_wb_dat <= {24'h000000, flash_protection};
          `IDX_SECURITY: o_wb_dat <= {24'h000000, security_register};
          `IDX_VIOL_STATUS: o_wb_dat <= {31'h00000000, o_protection_violation_flag};
          `IDX_STATUS_IN: o_wb_dat <= {30'h00000000, i_commands_complete_flag, i_buffer_empty_flag};
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

  assign o_wb_ack = ack;

  // ==========================================================================
  // Interrupt requests are plain gated levels
  assign o_buffer_empty_irq = flash_config[`CFG_BEIE_BIT] && i_buffer_empty_flag;
  assign o_command_complete_irq = flash_config[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] && i_commands_complete_flag;

  // Array access steering by the key-write bit
  assign o_start_command = i_array_write && !flash_config[`CFG_KEYW_BIT];
  assign o_key_word_write = i_array_write && flash_config[`CFG_KEYW_BIT];
  assign o_read_invalid = flash_config[`CFG_KEYW_BIT];

  // ==========================================================================
  // Command protection check against the live register
  wire addr_protected;
  wire fully_open;
  prot_range_check u_check (
    .i_prot(flash_protection),
    .i_addr(i_cmd_addr),
    .o_protected(addr_protected),
    .o_fully_open(fully_open)
  );

  wire cmd_blocked = i_cmd_mass_erase ? !fully_open : addr_protected;
  assign o_cmd_allow = i_cmd_valid && running && !cmd_blocked;

  // Sticky violation flag; a new violation beats a clear in the same cycle
  always @(posedge i_clock) begin
    if (!i_rst_n)
      o_protection_violation_flag <= 1'b0;
    else if (i_cmd_valid && cmd_blocked)
      o_protection_violation_flag <= 1'b1;
    else if (i_viol_clear)
      o_protection_violation_flag <= 1'b0;
  end

endmodule

`default_nettype wire

//--- bench/flash_regs_chk.sv
// Purpose: port-level assertions for the flash configuration/protection block
// Assumes: one clock domain, synchronous active-low reset, one-cycle bus ack
// Notes: bound to every instance of the block by the statement at the foot
`default_nettype none
// ==========================================================================
// Checker
module flash_regs_chk (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_buffer_empty_flag,
  input wire logic i_commands_complete_flag,
  input wire logic o_buffer_empty_irq,
  input wire logic o_command_complete_irq,
  input wire logic i_array_write,
  input wire logic o_start_command,
  input wire logic o_key_word_write,
  input wire logic o_read_invalid,
  input wire logic i_cmd_valid,
  input wire logic o_cmd_allow,
  input wire logic o_protection_violation_flag,
  input wire logic o_load_req,
  input wire logic [15:0] o_load_addr,
  input wire logic i_load_valid,
  input wire logic o_load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Bus handshake: answer one cycle after taking, never held, data zero when idle
  a_ack_next_cycle: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000) else $error("stale read data");
  // Interrupt requests only with their flag
  a_beirq_gated: assert property (o_buffer_empty_irq |-> i_buffer_empty_flag) else $error("irq no flag");
  a_ccirq_gated: assert property (o_command_complete_irq |-> i_commands_complete_flag) else $error("irq no flag");
  // Array writes steered by the key-write bit; exactly one path fires
  a_write_starts_cmd: assert property (i_array_write && !o_read_invalid |-> o_start_command && !o_key_word_write)
    else $error("array write not a command");
  a_write_is_key: assert property (i_array_write && o_read_invalid |-> o_key_word_write && !o_start_command)
    else $error("array write not a key");
  // Blocked command raises the sticky violation flag next edge
  a_viol_on_block: assert property (i_cmd_valid && !o_cmd_allow |=> o_protection_violation_flag)
    else $error("violation flag missing");
  // Loader starts at the security byte and ends on the protection byte
  a_load_first_addr: assert property ($rose(o_load_req) |-> o_load_addr == 16'hFF0F) else $error("load order");
  a_load_finish: assert property (o_load_req && i_load_valid && o_load_addr == 16'hFF0D |=> o_load_done && !o_load_req)
    else $error("load not finished");
  cover property (o_key_word_write);
  cover property ($rose(o_protection_violation_flag));
  cover property ($rose(o_load_done));
endmodule

bind flash_config_protection_regs flash_regs_chk chk_u (.*);
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: directed bench for the flash configuration/protection registers
// Assumes: 25 MHz clock, one-cycle Wishbone ack, loader bytes fed by the bench
// Notes: each scenario is a task that judges its own results
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, i_load_valid = 1'b0;
  logic i_buffer_empty_flag = 1'b1, i_commands_complete_flag = 1'b1, i_array_write = 1'b0;
  logic i_cmd_valid = 1'b0, i_cmd_mass_erase = 1'b0, i_viol_clear = 1'b0;
  logic [5:0] i_wb_adr = 6'h00;
  logic [3:0] i_wb_sel = 4'h1;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic [7:0] i_load_data = 8'h00, rd;
  logic [15:0] i_cmd_addr = 16'h0000;
  wire [31:0] o_wb_dat;
  wire [15:0] o_load_addr;
  wire o_wb_ack, o_load_req, o_buffer_empty_irq, o_command_complete_irq, o_start_command, o_key_word_write;
  wire o_read_invalid, o_cmd_allow, o_protection_violation_flag, o_load_done;
  int miscompares = 0, samples_checked = 0;
  flash_config_protection_regs dut_u (.*);
  // 40 ns period
  always #20 i_clock = ~i_clock;
  // ==========================================================================
  // Drivers
  task automatic feed(input logic [7:0] b);
    i_load_valid <= 1'b1;
    i_load_data <= b;
    @(posedge i_clock);
    i_load_valid <= 1'b0;
  endtask
  // Reset, then answer the loader: security byte first, protection byte second
  task automatic do_reset(input logic [7:0] sec, input logic [7:0] prot);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    while (o_load_req !== 1'b1) @(posedge i_clock);
    `CHK(o_load_addr, 16'hFF0F)
    feed(sec);
    @(posedge i_clock);
    `CHK(o_load_addr, 16'hFF0D)
    feed(prot);
    @(posedge i_clock);
    `CHK(o_load_done, 1'b1)
  endtask
  // Classic cycle; waits for ack however long it takes, watchdog bounds it
  task automatic wb(input logic we, input logic [5:0] adr, input logic [7:0] wd);
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= {24'h000000, wd};
    do @(posedge i_clock); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic wr_rd(input logic [5:0] adr, input logic [7:0] wd, input logic [7:0] exp);
    wb(1'b1, adr, wd);
    wb(1'b0, adr, 8'h00);
    `CHK(rd, exp)
  endtask
  task automatic arr(input logic [1:0] exp);
    i_array_write <= 1'b1;
    @(posedge i_clock);
    `CHK({o_start_command, o_key_word_write}, exp)
    i_array_write <= 1'b0;
  endtask
  // Clear rides on the edge after the check so the flag is seen first
  task automatic cmd(input logic [15:0] adr, input logic mass, input logic allow);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_addr <= adr;
    i_cmd_mass_erase <= mass;
    @(posedge i_clock);
    `CHK(o_cmd_allow, allow)
    i_cmd_valid <= 1'b0;
    i_viol_clear <= 1'b1;
    @(posedge i_clock);
    `CHK(o_protection_violation_flag, !allow)
    i_viol_clear <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_cfg;
    wr_rd(6'h0C, 8'hFF, 8'hE0);
    `CHK({o_buffer_empty_irq, o_command_complete_irq, o_read_invalid}, 3'b111)
    arr(2'b01);
    i_buffer_empty_flag <= 1'b0;
    @(posedge i_clock);
    `CHK(o_buffer_empty_irq, 1'b0)
    i_buffer_empty_flag <= 1'b1;
    wr_rd(6'h0C, 8'h00, 8'h00);
    `CHK({o_buffer_empty_irq, o_command_complete_irq, o_read_invalid}, 3'b000)
    arr(2'b10);
    wb(1'b0, 6'h3C, 8'h00);
    `CHK(rd, 8'h00)
    wb(1'b0, 6'h20, 8'h00);
    `CHK(rd, 8'h80)
    wb(1'b0, 6'h28, 8'h00);
    `CHK(rd, 8'h03)
    wb(1'b0, 6'h24, 8'h00);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_low;
    cmd(16'hFFFF, 1'b1, 1'b1);
    wr_rd(6'h10, 8'hFB, 8'hFB);
    cmd(16'h5FFF, 1'b0, 1'b0);
    cmd(16'h6000, 1'b0, 1'b1);
    cmd(16'h8000, 1'b1, 1'b0);
    wr_rd(6'h10, 8'hFF, 8'hFB);
    wr_rd(6'h10, 8'hF8, 8'hFB);
    wr_rd(6'h10, 8'h7B, 8'hFB);
  endtask
  task automatic t_high;
    wr_rd(6'h10, 8'hC7, 8'hC7);
    cmd(16'hF800, 1'b0, 1'b0);
    cmd(16'hF7FF, 1'b0, 1'b1);
    wr_rd(6'h10, 8'hDF, 8'hC7);
  endtask
  // Polarity low with both disables set protects the whole array
  task automatic t_pol0;
    wr_rd(6'h10, 8'hFF, 8'h7F);
    cmd(16'h8000, 1'b0, 1'b0);
    cmd(16'h0000, 1'b1, 1'b0);
  endtask
  // Key field codes other than 10 lock the key-write bit
  task automatic t_keylock;
    for (int e = 0; e < 4; e++) begin
      if (e != 2) begin
        do_reset({e[1:0], 6'h00}, 8'hFF);
        wr_rd(6'h0C, 8'hFF, 8'hC0);
      end
    end
  endtask
  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic results;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset(8'h80, 8'hFF);
    t_cfg();
    t_low();
    do_reset(8'h80, 8'hFF);
    t_high();
    do_reset(8'h80, 8'h7F);
    t_pol0();
    t_keylock();
    results();
  end
  // About 270 cycles expected; generous margin
  initial begin
    #200us;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
